// *** logic/fcs_params.svh ***
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_CLK_NS     8
`define FCS_PROG_NS    400
`define FCS_ERASE_NS   800
`define FCS_LOCK_NS    200
`define FCS_CYC(ns)    16'((((ns) + `FCS_CLK_NS - 1) / `FCS_CLK_NS) - 1)
`define FCS_OFF_CTRL   12'h000
`define FCS_OFF_STAT   12'h004
`define FCS_OFF_FLASH  12'h100
`define FCS_OFF_END    12'h1A0
`define FCS_NBLK       10
`define FCS_NWORD      40
`define FCS_BLK_WORDS  4
`define FCS_LAST_EALL  4'h8
`define FCS_TOP_WORD   2'h3
`define FCS_STRB16     4'h3
`define FCS_CMD_ARRAY  8'hFF
`define FCS_CMD_STAT   8'h70
`define FCS_CMD_CLR    8'h50
`define FCS_CMD_PROG   8'h40
`define FCS_CMD_ERASE  8'h20
`define FCS_CMD_EALL   8'hA7
`define FCS_CMD_LOCK   8'h77
`define FCS_CMD_RLOCK  8'h71
`define FCS_CMD_GO     8'hD0
`define FCS_ERASED     16'hFFFF
`define FCS_RESP_OKAY  2'h0
`define FCS_RESP_SLV   2'h2
`endif

// *** logic/fcs_pkg.sv ***
`include "fcs_params.svh"
package fcs_pkg;
	typedef enum logic [0:0] {RD_ARRAY = 1'b0, RD_STATUS = 1'b1} fcs_rmode_e;
	typedef enum logic [2:0] {P_NONE = 3'b000, P_PROG = 3'b001, P_ERASE = 3'b010,
		P_EALL = 3'b011, P_LOCK = 3'b100, P_RLOCK = 3'b101} fcs_pend_e;
	typedef enum logic [2:0] {OP_IDLE = 3'b000, OP_PROG = 3'b001, OP_ERASE = 3'b010,
		OP_LOCK = 3'b011, OP_RLOCK = 3'b100} fcs_op_e;
	typedef struct packed {
		logic                             awready;
		logic                             wready;
		logic                             bvalid;
		logic [1:0]                       bresp;
		logic                             arready;
		logic                             rvalid;
		logic [1:0]                       rresp;
		logic [31:0]                      rdata;
		logic                             aw_held;
		logic                             w_held;
		logic [11:0]                      awaddr;
		logic [31:0]                      wdata;
		logic [3:0]                       wstrb;
		fcs_rmode_e                       rmode;
		fcs_pend_e                        pend;
		logic [5:0]                       pend_word;
		fcs_op_e                          op;
		logic                             eall;
		logic [5:0]                       op_word;
		logic [3:0]                       op_blk;
		logic [15:0]                      op_data;
		logic [15:0]                      cnt;
		logic                             ready;
		logic                             prog_err;
		logic                             erase_err;
		logic                             lock_res;
		logic                             lock_dis;
		logic                             flash_exec;
		logic [`FCS_NBLK-1:0]             lock_bits;
		logic [`FCS_NWORD-1:0][15:0]      mem;
	} fcs_state_s;
endpackage

// *** logic/fcs_top.sv ***
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
// Contract
// - commands travel only as 16-bit writes to even user-area addresses
// - upper byte of a command write is ignored
// - code FF enters read-array mode, which persists until another command
// - after code 70 reads of the flash area return status
// - code 50 clears program and erase error flags
// - code 40 then data at same address starts auto program
// - busy/ready reads 0 during programming, 1 after
// - program error flag holds the programming outcome
// - in RAM-executed mode an operation switches reads to status; codes 71 then D0 switch reads to array instead
// - codes 20 then D0 at block top address erase that block
// - busy during erase; erase error flag reports the result
// - after erase in RAM-executed mode status reads persist
// - erase-all erases unlocked blocks 0 to 8 in turn, never block 9
// - codes 77 then D0 at same top address lock that block
// - codes 71 then D0 copy the block lock bit to the lock result
// - lock bit 0 blocks program and erase unless lock protection disabled
// - status sits on read data bits 7 down to 0
// - any error flag set refuses program, erase, erase-all, lock program
// - sequencer status is 0 during any operation, 1 when it ends
// - FF as second cycle cancels the command and enters read-array; after code 40 it is taken as program data instead
module fcs_top #(
	parameter bit FORCE_FAIL = 1'b0
) (
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [11:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [11:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             busy_ready_flag_o
);
	fcs_pkg::fcs_state_s q;
	fcs_pkg::fcs_state_s next_q;
	logic [`FCS_NBLK-1:0] blk_ok;
	logic [11:0]          w_off;
	logic [11:0]          r_off;
	logic [5:0]           word;
	logic [5:0]           rword;
	logic                 in_flash;
	logic                 ar_flash;
	logic                 wr_go;
	logic                 cmd_wr;
	logic                 err;
	logic [7:0]           code;
	logic [7:0]           status_read_value;

	genvar gb;
	generate
		for (gb = 0; gb < `FCS_NBLK; gb++)
		begin : g_blk
			assign blk_ok[gb] = q.lock_dis | q.lock_bits[gb];
		end
	endgenerate

	assign w_off    = q.awaddr - `FCS_OFF_FLASH;
	assign r_off    = s_axi_araddr_i - `FCS_OFF_FLASH;
	assign word     = w_off[7:2];
	assign rword    = r_off[7:2];
	assign in_flash = q.awaddr >= `FCS_OFF_FLASH && q.awaddr < `FCS_OFF_END;
	assign ar_flash = s_axi_araddr_i >= `FCS_OFF_FLASH && s_axi_araddr_i < `FCS_OFF_END;
	assign wr_go    = q.aw_held && q.w_held && !q.bvalid;
	assign cmd_wr   = wr_go && in_flash && q.wstrb == `FCS_STRB16 && q.ready;
	assign code     = q.wdata[7:0];
	assign err      = q.prog_err | q.erase_err;
	assign status_read_value = {q.ready, 1'b0, q.erase_err, q.prog_err, 4'h0};

	always_comb
	begin
		next_q = q;
		if (s_axi_awvalid_i && q.awready)
		begin
			next_q.awready = 1'b0;
			next_q.aw_held = 1'b1;
			next_q.awaddr  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && q.wready)
		begin
			next_q.wready = 1'b0;
			next_q.w_held = 1'b1;
			next_q.wdata  = s_axi_wdata_i;
			next_q.wstrb  = s_axi_wstrb_i;
		end
		if (q.bvalid && s_axi_bready_i)
		begin
			next_q.bvalid  = 1'b0;
			next_q.awready = 1'b1;
			next_q.wready  = 1'b1;
		end
		if (q.op != fcs_pkg::OP_IDLE)
		begin
			if (q.cnt != 16'h0)
				next_q.cnt = q.cnt - 16'h1;
			else
			begin
				next_q.op    = fcs_pkg::OP_IDLE;
				next_q.ready = 1'b1;
				case (q.op)
					fcs_pkg::OP_PROG:
						if (FORCE_FAIL)
							next_q.prog_err = 1'b1;
						else
							next_q.mem[q.op_word] = q.mem[q.op_word] & q.op_data;
					fcs_pkg::OP_ERASE:
					begin
						if (FORCE_FAIL)
							next_q.erase_err = 1'b1;
						else if (blk_ok[q.op_blk])
						begin
							for (int i = 0; i < `FCS_BLK_WORDS; i++)
								next_q.mem[{q.op_blk, 2'(i)}] = `FCS_ERASED;
							next_q.lock_bits[q.op_blk] = 1'b1;
						end
						if (q.eall && q.op_blk != `FCS_LAST_EALL)
						begin
							next_q.op     = fcs_pkg::OP_ERASE;
							next_q.ready  = 1'b0;
							next_q.op_blk = q.op_blk + 4'h1;
							next_q.cnt    = `FCS_CYC(`FCS_ERASE_NS);
						end
					end
					fcs_pkg::OP_LOCK:
						next_q.lock_bits[q.op_blk] = 1'b0;
					fcs_pkg::OP_RLOCK:
						next_q.lock_res = q.lock_bits[q.op_blk];
					default:
						next_q.ready = 1'b1;
				endcase
			end
		end
		if (wr_go)
		begin
			next_q.aw_held = 1'b0;
			next_q.w_held  = 1'b0;
			next_q.bvalid  = 1'b1;
			next_q.bresp   = `FCS_RESP_OKAY;
			if (q.awaddr == `FCS_OFF_CTRL)
			begin
				if (q.wstrb[0])
				begin
					next_q.lock_dis   = q.wdata[0];
					next_q.flash_exec = q.wdata[1];
				end
			end
			else if (q.awaddr != `FCS_OFF_STAT && !(in_flash && q.wstrb == `FCS_STRB16))
				next_q.bresp = `FCS_RESP_SLV;
		end
		if (cmd_wr)
		begin
			if (q.pend == fcs_pkg::P_NONE)
			begin
				case (code)
					`FCS_CMD_ARRAY: next_q.rmode = fcs_pkg::RD_ARRAY;
					`FCS_CMD_STAT:  next_q.rmode = fcs_pkg::RD_STATUS;
					`FCS_CMD_CLR:
					begin
						next_q.prog_err  = 1'b0;
						next_q.erase_err = 1'b0;
					end
					`FCS_CMD_PROG:  if (!err) next_q.pend = fcs_pkg::P_PROG;
					`FCS_CMD_ERASE: if (!err) next_q.pend = fcs_pkg::P_ERASE;
					`FCS_CMD_EALL:  if (!err) next_q.pend = fcs_pkg::P_EALL;
					`FCS_CMD_LOCK:  if (!err) next_q.pend = fcs_pkg::P_LOCK;
					`FCS_CMD_RLOCK: next_q.pend = fcs_pkg::P_RLOCK;
					default:
					begin
						next_q.prog_err  = 1'b1;
						next_q.erase_err = 1'b1;
					end
				endcase
				next_q.pend_word = word;
			end
			else
			begin
				next_q.pend    = fcs_pkg::P_NONE;
				next_q.op_word = word;
				next_q.op_blk  = word[5:2];
				next_q.op_data = q.wdata[15:0];
				next_q.eall    = 1'b0;
				if (q.pend == fcs_pkg::P_PROG)
				begin
					if (word != q.pend_word)
					begin
						next_q.prog_err  = 1'b1;
						next_q.erase_err = 1'b1;
					end
					else if (!blk_ok[word[5:2]])
						next_q.prog_err = 1'b1;
					else
					begin
						next_q.op  = fcs_pkg::OP_PROG;
						next_q.cnt = `FCS_CYC(`FCS_PROG_NS);
					end
				end
				else if (code == `FCS_CMD_ARRAY)
					next_q.rmode = fcs_pkg::RD_ARRAY;
				else if (code != `FCS_CMD_GO || (q.pend != fcs_pkg::P_EALL
					&& word[1:0] != `FCS_TOP_WORD)
					|| (q.pend == fcs_pkg::P_LOCK && word != q.pend_word))
				begin
					next_q.prog_err  = 1'b1;
					next_q.erase_err = 1'b1;
				end
				else
					case (q.pend)
						fcs_pkg::P_ERASE:
							if (!blk_ok[word[5:2]])
								next_q.erase_err = 1'b1;
							else
							begin
								next_q.op  = fcs_pkg::OP_ERASE;
								next_q.cnt = `FCS_CYC(`FCS_ERASE_NS);
							end
						fcs_pkg::P_EALL:
						begin
							next_q.op     = fcs_pkg::OP_ERASE;
							next_q.eall   = 1'b1;
							next_q.op_blk = 4'h0;
							next_q.cnt    = `FCS_CYC(`FCS_ERASE_NS);
						end
						fcs_pkg::P_LOCK:
						begin
							next_q.op  = fcs_pkg::OP_LOCK;
							next_q.cnt = `FCS_CYC(`FCS_LOCK_NS);
						end
						fcs_pkg::P_RLOCK:
						begin
							next_q.op    = fcs_pkg::OP_RLOCK;
							next_q.cnt   = `FCS_CYC(`FCS_LOCK_NS);
							next_q.rmode = fcs_pkg::RD_ARRAY;
						end
						default:
							next_q.op = fcs_pkg::OP_IDLE;
					endcase
				if (next_q.op != fcs_pkg::OP_IDLE)
				begin
					next_q.ready = 1'b0;
					if (!q.flash_exec && next_q.op != fcs_pkg::OP_RLOCK)
						next_q.rmode = fcs_pkg::RD_STATUS;
				end
			end
		end
		if (s_axi_arvalid_i && q.arready)
		begin
			next_q.arready = 1'b0;
			next_q.rvalid  = 1'b1;
			next_q.rresp   = `FCS_RESP_OKAY;
			next_q.rdata   = 32'h0;
			if (s_axi_araddr_i == `FCS_OFF_CTRL)
				next_q.rdata = {30'h0, q.flash_exec, q.lock_dis};
			else if (s_axi_araddr_i == `FCS_OFF_STAT)
				next_q.rdata = {28'h0, q.lock_res, q.erase_err, q.prog_err, q.ready};
			else if (ar_flash && q.rmode == fcs_pkg::RD_STATUS)
				next_q.rdata = {24'h0, status_read_value};
			else if (ar_flash)
				next_q.rdata = {16'h0, q.mem[rword]};
			else
				next_q.rresp = `FCS_RESP_SLV;
		end
		if (q.rvalid && s_axi_rready_i)
		begin
			next_q.rvalid  = 1'b0;
			next_q.arready = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			q           <= '0;
			q.awready   <= 1'b1;
			q.wready    <= 1'b1;
			q.arready   <= 1'b1;
			q.ready     <= 1'b1;
			q.lock_bits <= '1;
			q.mem       <= '1;
		end
		else
			q <= next_q;
	end

	assign s_axi_awready_o   = q.awready;
	assign s_axi_wready_o    = q.wready;
	assign s_axi_bvalid_o    = q.bvalid;
	assign s_axi_bresp_o     = q.bresp;
	assign s_axi_arready_o   = q.arready;
	assign s_axi_rvalid_o    = q.rvalid;
	assign s_axi_rresp_o     = q.rresp;
	assign s_axi_rdata_o     = q.rdata;
	assign busy_ready_flag_o = q.ready;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_op_end;
		q.op != fcs_pkg::OP_IDLE ##0 next_q.op == fcs_pkg::OP_IDLE;
	endsequence
	property p_start_busy;
		q.op == fcs_pkg::OP_IDLE && next_q.op != fcs_pkg::OP_IDLE |=> !q.ready;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("ready not cleared");
	property p_end_ready;
		s_op_end |=> q.ready;
	endproperty
	a_end_ready: assert property (p_end_ready) else $error("ready not set");
	property p_refuse;
		err |-> !(q.op == fcs_pkg::OP_IDLE && next_q.op != fcs_pkg::OP_IDLE
			&& next_q.op != fcs_pkg::OP_RLOCK);
	endproperty
	a_refuse: assert property (p_refuse) else $error("command taken with error");
	property p_clear;
		cmd_wr && q.pend == fcs_pkg::P_NONE && code == `FCS_CMD_CLR |=> !err;
	endproperty
	a_clear: assert property (p_clear) else $error("errors not cleared");
	property p_status_mode;
		cmd_wr && !q.flash_exec && next_q.op != fcs_pkg::OP_IDLE
			&& next_q.op != fcs_pkg::OP_RLOCK |=> q.rmode == fcs_pkg::RD_STATUS;
	endproperty
	a_status_mode: assert property (p_status_mode) else $error("no status mode");
	property p_status_byte;
		s_axi_arvalid_i && q.arready && ar_flash && q.rmode == fcs_pkg::RD_STATUS
			|=> q.rdata[31:8] == 24'h0 && q.rdata[7] == $past(q.ready);
	endproperty
	a_status_byte: assert property (p_status_byte) else $error("bad status read");
	property p_cancel;
		cmd_wr && q.pend != fcs_pkg::P_NONE && q.pend != fcs_pkg::P_PROG
			&& code == `FCS_CMD_ARRAY |=> q.pend == fcs_pkg::P_NONE
			&& q.rmode == fcs_pkg::RD_ARRAY && q.ready;
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel failed");
	property p_lock_guard;
		q.op == fcs_pkg::OP_IDLE && next_q.op == fcs_pkg::OP_PROG |-> blk_ok[word[5:2]];
	endproperty
	a_lock_guard: assert property (p_lock_guard) else $error("locked block written");
	property p_prog_data;
		cmd_wr && q.pend == fcs_pkg::P_PROG && word == q.pend_word && blk_ok[word[5:2]]
			|=> q.op == fcs_pkg::OP_PROG && q.op_data == $past(q.wdata[15:0]);
	endproperty
	a_prog_data: assert property (p_prog_data) else $error("program not started");
endmodule
`default_nettype wire

// *** test/fcs_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_cpu_model (
	input  wire logic        ref_clk_i,
	output logic [11:0]      awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic [11:0]      araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	initial
	begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge ref_clk_i);
		awaddr_o  <= a;
		wdata_o   <= d;
		wstrb_o   <= s;
		awvalid_o <= 1'b1;
		wvalid_o  <= 1'b1;
		bready_o  <= 1'b1;
		forever
		begin
			@(posedge ref_clk_i);
			if (awready_i)
				awvalid_o <= 1'b0;
			if (wready_i)
				wvalid_o <= 1'b0;
			if (bvalid_i)
			begin
				r = bresp_i;
				bready_o <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk_i);
		araddr_o  <= a;
		arvalid_o <= 1'b1;
		rready_o  <= 1'b1;
		forever
		begin
			@(posedge ref_clk_i);
			if (arready_i)
				arvalid_o <= 1'b0;
			if (rvalid_i)
			begin
				d = rdata_i;
				r = rresp_i;
				rready_o <= 1'b0;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// *** test/fcs_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
module fcs_top_bench;
	logic        ref_clk_i;
	logic        sys_rst_i;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rdv;
	logic [31:0] seed;
	logic [3:0]  wstrb;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [1:0]  rsp;
	logic        awvalid;
	logic        awready;
	logic        wvalid;
	logic        wready;
	logic        bvalid;
	logic        bready;
	logic        arvalid;
	logic        arready;
	logic        rvalid;
	logic        rready;
	logic        busy_rdy;
	logic [15:0] dat [4];
	int          wrd [4];
	int          n_errors;
	int          cmp_count;
	fcs_top dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .busy_ready_flag_o(busy_rdy));
	fcs_cpu_model cpu (.ref_clk_i(ref_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
		.wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
		.araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
		.rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
	always
		#4 ref_clk_i = ~ref_clk_i;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] stat(input logic r, input logic e, input logic p);
		return {24'h0, r, 1'b0, e, p, 4'h0};
	endfunction
	function automatic logic [11:0] fa(input int i);
		return 12'(`FCS_OFF_FLASH + 4 * i);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic put(input int i, input logic [15:0] d);
		seed = xs(seed);
		cpu.wr(fa(i), {seed[31:16], d}, `FCS_STRB16, rsp);
	endtask
	task automatic cw(input int i, input logic [7:0] c);
		seed = xs(seed);
		put(i, {seed[7:0], c});
	endtask
	task automatic rd(input int i);
		cpu.rd(fa(i), rdv, rsp);
	endtask
	task automatic wait_rdy();
		rdv = 32'h0;
		for (int n = 0; n < 3000 && rdv[0] !== 1'b1; n++)
			cpu.rd(`FCS_OFF_STAT, rdv, rsp);
		chk(rdv[0], 1'b1);
	endtask
	task automatic two(input int i, input logic [7:0] c);
		cw(i, c);
		cw(i, `FCS_CMD_GO);
		wait_rdy();
	endtask
	task automatic give_verdict();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		n_errors++;
		give_verdict();
	end
	initial
	begin
		ref_clk_i = 1'b0;
		sys_rst_i = 1'b1;
		seed      = 32'h37;
		n_errors  = 0;
		cmp_count = 0;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		// main clock runs throughout and flash-executed mode stays off until the last test turns it on
		cpu.rd(`FCS_OFF_STAT, rdv, rsp);
		chk(rdv, 32'h1);
		rd(0);
		chk(rdv, 32'hFFFF);
		cpu.rd(12'h050, rdv, rsp);
		chk(rsp, `FCS_RESP_SLV);
		cpu.wr(fa(1), 32'h40, 4'hF, rsp);
		chk(rsp, `FCS_RESP_SLV);
		cw(1, `FCS_CMD_STAT);
		rd(3);
		chk(rdv, stat(1'b1, 1'b0, 1'b0));
		$display("test reset and status done");
		for (int k = 0; k < 4; k++)
		begin
			seed   = xs(seed);
			wrd[k] = 4 * k + int'(seed[9:8] % 2'h3);
			dat[k] = seed[15:0];
			cw(wrd[k], `FCS_CMD_PROG);
			put(wrd[k], dat[k]);
			@(posedge ref_clk_i);
			chk(busy_rdy, 1'b0);
			rd(39 - k);
			chk(rdv, stat(1'b0, 1'b0, 1'b0));
			wait_rdy();
			rd(k);
			chk(rdv, stat(1'b1, 1'b0, 1'b0));
			cw(k, `FCS_CMD_ARRAY);
			rd(wrd[k]);
			chk(rdv, {16'h0, dat[k]});
			rd(wrd[k]);
			chk(rdv, {16'h0, dat[k]});
		end
		$display("test program done");
		two(3, `FCS_CMD_RLOCK);
		chk(rdv, 32'h9);
		two(11, `FCS_CMD_LOCK);
		two(11, `FCS_CMD_RLOCK);
		chk(rdv, 32'h1);
		cw(11, `FCS_CMD_PROG);
		put(11, 16'h1234);
		wait_rdy();
		chk(rdv, 32'h3);
		cw(3, `FCS_CMD_PROG);
		put(3, 16'h5555);
		wait_rdy();
		cw(0, `FCS_CMD_ARRAY);
		rd(11);
		chk(rdv, 32'hFFFF);
		rd(3);
		chk(rdv, 32'hFFFF);
		cw(0, `FCS_CMD_CLR);
		cpu.rd(`FCS_OFF_STAT, rdv, rsp);
		chk(rdv, 32'h1);
		cw(7, `FCS_CMD_ERASE);
		cw(7, `FCS_CMD_ARRAY);
		rd(wrd[1]);
		chk(rdv, {16'h0, dat[1]});
		cpu.rd(`FCS_OFF_STAT, rdv, rsp);
		chk(rdv, 32'h1);
		$display("test lock and cancel done");
		cpu.wr(`FCS_OFF_CTRL, 32'h1, 4'hF, rsp);
		cw(11, `FCS_CMD_ERASE);
		cw(11, `FCS_CMD_GO);
		@(posedge ref_clk_i);
		chk(busy_rdy, 1'b0);
		wait_rdy();
		chk(rdv, 32'h1);
		rd(0);
		chk(rdv, stat(1'b1, 1'b0, 1'b0));
		rd(5);
		chk(rdv, stat(1'b1, 1'b0, 1'b0));
		cw(0, `FCS_CMD_ARRAY);
		rd(wrd[2]);
		chk(rdv, 32'hFFFF);
		cpu.wr(`FCS_OFF_CTRL, 32'h0, 4'hF, rsp);
		$display("test block erase done");
		two(15, `FCS_CMD_LOCK);
		cw(36, `FCS_CMD_PROG);
		put(36, dat[0]);
		wait_rdy();
		two(2, `FCS_CMD_EALL);
		chk(rdv, 32'h1);
		cw(0, `FCS_CMD_ARRAY);
		rd(wrd[0]);
		chk(rdv, 32'hFFFF);
		rd(wrd[1]);
		chk(rdv, 32'hFFFF);
		rd(wrd[3]);
		chk(rdv, {16'h0, dat[3]});
		rd(36);
		chk(rdv, {16'h0, dat[0]});
		$display("test erase all done");
		cpu.wr(`FCS_OFF_CTRL, 32'h2, 4'hF, rsp);
		chk(rsp, `FCS_RESP_OKAY);
		cpu.rd(`FCS_OFF_CTRL, rdv, rsp);
		chk(rsp, `FCS_RESP_OKAY);
		chk(rdv, 32'h2);
		cw(37, `FCS_CMD_PROG);
		put(37, dat[2]);
		rd(37);
		chk(rdv, 32'hFFFF);
		wait_rdy();
		rd(37);
		chk(rdv, {16'h0, dat[2]});
		$display("test flash-executed mode done");
		give_verdict();
	end
endmodule
`default_nettype wire
